// file: shared/node_discovery_defines.svh
// Constants for the node discovery command block.
// Assumes a single 250 MHz system clock.
`ifndef NODE_DISCOVERY_DEFINES_SVH
`define NODE_DISCOVERY_DEFINES_SVH
`define CLK_PERIOD_PS 4000
`define TIMEOUT_UNIT_MS 100
`define CYCLES_PER_MS 250000
`define TIMEOUT_RESET 8'h19
`define COMPAT_BIT 1
`define LONG_ADDR_FLAG 16'hFFFE
`define API_RESP_FRAME 8'h88
`define REG_CTRL 4'h0
`define REG_CMD 4'h1
`define REG_TIMEOUT 4'h2
`define REG_COMPAT 4'h3
`define REG_DEST_HI 4'h4
`define REG_DEST_LO 4'h5
`define REG_STATUS 4'h6
`define REG_IRQ_STAT 4'h7
`define REG_IRQ_EN 4'h8
`define REG_IRQ_CLR 4'h9
`define REG_LABEL 4'hA
`define CMD_DISCOVER 2'h1
`define CMD_DIRECTED 2'h2
`define CMD_LOOKUP 2'h3
`define IRQ_DONE 0
`define IRQ_ERROR 1
`define IRQ_REPLY 2
`define IRQ_CRLF 3
`define IRQ_W 4
`endif

// file: shared/node_discovery_pkg.sv
// Types for the node discovery command block.
// Included by the design; no logic here.
package node_discovery_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WAIT = 5'h02,
    ST_HOLD = 5'h04,
    ST_OK = 5'h08,
    ST_ERR = 5'h10
  } state_t;
  typedef enum logic [1:0] {
    RES_NONE = 2'h0,
    RES_OK = 2'h1,
    RES_ERR = 2'h2,
    RES_CRLF = 2'h3
  } result_t;
endpackage

// file: hdl/node_discovery_control.sv
// Node discovery command interpreter: discover, directed discover, destination lookup.
// Assumes an Avalon-MM master for registers and a radio layer that broadcasts and returns replies.
// Function
// - Discovery without label broadcasts to every node on current network.
// - Transparent-mode discovery blocks all other commands until timeout elapses.
// - Transparent discovery timeout emits one extra CRLF, replies or not.
// - API discovery forwards replies as frames; silence on none; still blocks.
// - Compat bit 1 in API with no reply sends an OK response frame.
// - Directed discovery broadcasts a label; only matching node replies.
// - Transparent directed: after reply emit CRLF, end, accept commands.
// - Transparent directed: no timely reply gives ERROR at timeout.
// - API directed: forward reply frame and end immediately.
// - API directed: no reply gives error frame at timeout.
// - Compat bit 1 directed: end only at timeout, always success.
// - Lookup broadcasts label; first match loads destination registers, succeeds.
// - Lookup success: transparent outputs OK, leaves command mode; API stays.
// - Lookup without label ends at once with error, no broadcast.
// - Lookup with no matching answer ends with error at timeout.
// - Lookup never forwards responder information to the host.
// - Short responder address: clear high and upper low bits, load short.
// - Responder short FFFE: copy its serial halves to destination registers.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "node_discovery_defines.svh"
module node_discovery_control #(
  parameter int CYCLES_PER_UNIT = `CYCLES_PER_MS * `TIMEOUT_UNIT_MS
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Radio side
  output logic bcast_valid_out,
  output logic [1:0] bcast_kind_out,
  output logic [31:0] bcast_label_out,
  input wire logic reply_valid_in,
  input wire logic [15:0] reply_short_addr_in,
  input wire logic [31:0] reply_serial_high_in,
  input wire logic [31:0] reply_serial_low_in,
  // Host-facing result stream
  output logic fwd_reply_valid_out,
  output logic fwd_reply_api_out,
  output logic [1:0] result_out,
  output logic result_valid_out,
  output logic [7:0] result_frame_type_out,
  output logic cmd_mode_exit_out,
  output logic busy_out,
  // Interrupt
  output logic irq_out
);

  node_discovery_pkg::state_t state_q, state_d;
  logic [1:0] cmd_q;
  logic api_q;
  logic label_q;
  logic [31:0] label_text_q;
  logic [7:0] timeout_q;
  logic [1:0] compat_q;
  logic [31:0] dest_high_q;
  logic [31:0] dest_low_q;
  logic [7:0] units_q;
  logic [31:0] div_q;
  logic replied_q;
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_en_q;
  logic ack_q;
  logic [31:0] rdata_q;

  // Every access takes two cycles; a write acts only at the edge where waitrequest is low
  wire access = (avs_read_in | avs_write_in) & ~ack_q;
  wire wr = avs_write_in & ack_q;
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction
  wire wr_ctrl = wr & hit(avs_address_in, `REG_CTRL);
  wire wr_cmd = wr & hit(avs_address_in, `REG_CMD);
  wire idle = (state_q == node_discovery_pkg::ST_IDLE);
  wire [1:0] new_cmd = avs_writedata_in[1:0];
  wire new_label = avs_writedata_in[2];
  // Commands while busy are dropped; blocking is the point of the pending wait
  wire start = wr_cmd & idle & (new_cmd != 2'h0);
  wire compat = compat_q[`COMPAT_BIT];
  wire unit_tick = (div_q == 32'(CYCLES_PER_UNIT - 1));
  wire expired = (state_q == node_discovery_pkg::ST_WAIT || state_q == node_discovery_pkg::ST_HOLD)
                 && unit_tick && (units_q <= 8'h01);
  wire waiting = (state_q == node_discovery_pkg::ST_WAIT) || (state_q == node_discovery_pkg::ST_HOLD);
  wire got_reply = waiting & reply_valid_in;
  wire first_reply = (state_q == node_discovery_pkg::ST_WAIT) & reply_valid_in;
  wire is_long = (reply_short_addr_in == `LONG_ADDR_FLAG);
  wire lookup_hit = first_reply & (cmd_q == `CMD_LOOKUP);
  wire directed_hit = first_reply & (cmd_q == `CMD_DIRECTED);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      node_discovery_pkg::ST_IDLE: begin
        if (start) begin
          if (new_cmd == `CMD_LOOKUP && !new_label) begin
            state_d = node_discovery_pkg::ST_ERR;
          end else begin
            state_d = node_discovery_pkg::ST_WAIT;
          end
        end
      end
      node_discovery_pkg::ST_WAIT: begin
        if (lookup_hit) begin
          state_d = node_discovery_pkg::ST_OK;
        end else if (directed_hit && !compat) begin
          state_d = node_discovery_pkg::ST_OK;
        end else if (directed_hit) begin
          state_d = node_discovery_pkg::ST_HOLD;
        end else if (expired) begin
          state_d = node_discovery_pkg::ST_ERR;
        end
      end
      node_discovery_pkg::ST_HOLD: begin
        if (expired) begin
          state_d = node_discovery_pkg::ST_OK;
        end
      end
      node_discovery_pkg::ST_OK: state_d = node_discovery_pkg::ST_IDLE;
      node_discovery_pkg::ST_ERR: state_d = node_discovery_pkg::ST_IDLE;
      default: state_d = node_discovery_pkg::ST_IDLE;
    endcase
  end

  // Outcome of an ending command, decided in the cycle the state machine moves to ST_OK or ST_ERR
  logic [1:0] res_d;
  logic [7:0] frame_d;
  always_comb begin
    res_d = node_discovery_pkg::RES_NONE;
    frame_d = 8'h00;
    if (start && new_cmd == `CMD_LOOKUP && !new_label) begin
      res_d = node_discovery_pkg::RES_ERR;
    end else if (lookup_hit) begin
      res_d = node_discovery_pkg::RES_OK;
    end else if (directed_hit && !compat) begin
      res_d = api_q ? node_discovery_pkg::RES_NONE : node_discovery_pkg::RES_CRLF;
    end else if (expired) begin
      unique case (cmd_q)
        `CMD_DISCOVER: begin
          if (!api_q) begin
            res_d = node_discovery_pkg::RES_CRLF;
          end else if (compat && !replied_q && !got_reply) begin
            res_d = node_discovery_pkg::RES_OK;
          end else begin
            res_d = node_discovery_pkg::RES_NONE;
          end
        end
        `CMD_DIRECTED: begin
          if (compat) begin
            res_d = node_discovery_pkg::RES_OK;
          end else begin
            res_d = node_discovery_pkg::RES_ERR;
          end
        end
        default: res_d = node_discovery_pkg::RES_ERR;
      endcase
    end
    if (api_q && res_d != node_discovery_pkg::RES_NONE) begin
      frame_d = `API_RESP_FRAME;
    end
  end
  wire res_fire = (res_d != node_discovery_pkg::RES_NONE);

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= node_discovery_pkg::ST_IDLE;
      cmd_q <= 2'h0;
      label_q <= 1'b0;
      replied_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start) begin
        cmd_q <= new_cmd;
        label_q <= new_label;
      end
      replied_q <= start ? 1'b0 : (replied_q | got_reply);
    end
  end

  // Timeout counter: reload on start (zero counts as one unit); outside a wait units hold and the divider clears
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_q <= 32'h0;
      units_q <= 8'h0;
    end else if (start) begin
      div_q <= 32'h0;
      units_q <= (timeout_q == 8'h00) ? 8'h01 : timeout_q;
    end else if (waiting) begin
      div_q <= unit_tick ? 32'h0 : div_q + 32'h1;
      if (unit_tick && units_q != 8'h00) begin
        units_q <= units_q - 8'h01;
      end
    end else begin
      div_q <= 32'h0;
    end
  end

  // Broadcast request to the radio layer
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bcast_valid_out <= 1'b0;
      bcast_kind_out <= 2'h0;
      bcast_label_out <= 32'h0;
    end else begin
      bcast_valid_out <= start & (state_d == node_discovery_pkg::ST_WAIT);
      if (start) begin
        bcast_kind_out <= new_cmd;
        bcast_label_out <= new_label ? label_text_q : 32'h0;
      end
    end
  end

  // Reply forwarding and destination update
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fwd_reply_valid_out <= 1'b0;
      fwd_reply_api_out <= 1'b0;
      dest_high_q <= 32'h0;
      dest_low_q <= 32'h0;
    end else begin
      fwd_reply_api_out <= api_q;
      fwd_reply_valid_out <= got_reply & (cmd_q != `CMD_LOOKUP) &
                             (cmd_q == `CMD_DISCOVER || state_q == node_discovery_pkg::ST_WAIT);
      if (lookup_hit) begin
        if (is_long) begin
          dest_high_q <= reply_serial_high_in;
          dest_low_q <= reply_serial_low_in;
        end else begin
          dest_high_q <= 32'h0;
          dest_low_q <= {16'h0, reply_short_addr_in};
        end
      end else if (wr & hit(avs_address_in, `REG_DEST_HI) & idle) begin
        dest_high_q <= avs_writedata_in;
      end else if (wr & hit(avs_address_in, `REG_DEST_LO) & idle) begin
        dest_low_q <= avs_writedata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_out <= node_discovery_pkg::RES_NONE;
      result_valid_out <= 1'b0;
      result_frame_type_out <= 8'h00;
      cmd_mode_exit_out <= 1'b0;
    end else begin
      result_valid_out <= res_fire;
      result_out <= res_d;
      result_frame_type_out <= frame_d;
      cmd_mode_exit_out <= lookup_hit & ~api_q;
    end
  end

  // Software registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      api_q <= 1'b0;
      timeout_q <= `TIMEOUT_RESET;
      compat_q <= 2'h0;
      label_text_q <= 32'h0;
      irq_en_q <= '0;
    end else begin
      if (wr_ctrl) api_q <= avs_writedata_in[0];
      if (wr & hit(avs_address_in, `REG_TIMEOUT)) timeout_q <= avs_writedata_in[7:0];
      if (wr & hit(avs_address_in, `REG_COMPAT)) compat_q <= avs_writedata_in[1:0];
      if (wr & hit(avs_address_in, `REG_LABEL)) label_text_q <= avs_writedata_in;
      if (wr & hit(avs_address_in, `REG_IRQ_EN)) irq_en_q <= avs_writedata_in[`IRQ_W-1:0];
    end
  end

  // Sticky events: a set in the clearing cycle wins
  logic [`IRQ_W-1:0] irq_set;
  assign irq_set = {res_d == node_discovery_pkg::RES_CRLF, got_reply,
                    res_d == node_discovery_pkg::RES_ERR, res_fire};
  wire [`IRQ_W-1:0] irq_clr = (wr & hit(avs_address_in, `REG_IRQ_CLR)) ? avs_writedata_in[`IRQ_W-1:0] : '0;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end
  assign irq_out = |(irq_stat_q & irq_en_q);

  logic [31:0] rmux;
  always_comb begin
    unique case (avs_address_in)
      `REG_CTRL: rmux = {31'h0, api_q};
      `REG_TIMEOUT: rmux = {24'h0, timeout_q};
      `REG_COMPAT: rmux = {30'h0, compat_q};
      `REG_DEST_HI: rmux = dest_high_q;
      `REG_DEST_LO: rmux = dest_low_q;
      `REG_STATUS: rmux = {27'h0, label_q, cmd_q, replied_q, ~idle};
      `REG_IRQ_STAT: rmux = {28'h0, irq_stat_q};
      `REG_IRQ_EN: rmux = {28'h0, irq_en_q};
      `REG_LABEL: rmux = label_text_q;
      default: rmux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= access;
      if (avs_read_in & ~ack_q) rdata_q <= rmux;
    end
  end
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
  assign avs_readdata_out = rdata_q;
  assign busy_out = ~idle;

endmodule // node_discovery_control

// file: tb/node_discovery_control_props.sv
// Port-level checks for the node discovery block.
// Bound into every node_discovery_control; one clock domain.
`timescale 1ns/100ps
module node_discovery_props #(
  parameter int CYCLES_PER_UNIT = 10
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic avs_waitrequest_out,
  input wire logic bcast_valid_out,
  input wire logic [1:0] bcast_kind_out,
  input wire logic [31:0] bcast_label_out,
  input wire logic fwd_reply_valid_out,
  input wire logic [1:0] result_out,
  input wire logic result_valid_out,
  input wire logic cmd_mode_exit_out,
  input wire logic busy_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  logic [7:0] to_q;
  logic [1:0] kind_q;
  logic [15:0] len_q;
  wire wr_ok = avs_write_in && !avs_waitrequest_out;
  wire go = wr_ok && avs_address_in == 4'h1 && !busy_out;
  wire [31:0] to_cyc = (to_q == 8'h0 ? 32'h1 : {24'h0, to_q}) * CYCLES_PER_UNIT;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      to_q <= 8'h19;
      kind_q <= 2'h0;
      len_q <= 16'h0;
    end else begin
      if (wr_ok && avs_address_in == 4'h2) to_q <= avs_writedata_in[7:0];
      if (bcast_valid_out) kind_q <= bcast_kind_out;
      len_q <= busy_out ? len_q + 16'h1 : 16'h0;
    end
  end
  chk_wait_first: assert property ((avs_read_in || avs_write_in) && !$past(avs_read_in || avs_write_in)
    |-> avs_waitrequest_out) else $error("waitrequest low in first cycle");
  chk_wait_once: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("waitrequest longer than one cycle");
  chk_discover_bcast: assert property (go && avs_writedata_in[2:0] == 3'h1 |-> ##[1:3]
    bcast_valid_out && bcast_kind_out == 2'h1 && bcast_label_out == 32'h0) else $error("no discover broadcast");
  chk_named_bcast: assert property (bcast_valid_out && bcast_kind_out != 2'h1 |-> bcast_label_out != 32'h0)
    else $error("named broadcast without label");
  chk_nolabel_err: assert property (go && avs_writedata_in[2:0] == 3'h3 |-> ##[1:3]
    result_valid_out && result_out == 2'h2) else $error("unlabelled lookup gave no error");
  chk_nolabel_quiet: assert property (go && avs_writedata_in[2:0] == 3'h3 |=> !bcast_valid_out [*4])
    else $error("unlabelled lookup broadcast");
  chk_no_rebcast: assert property (busy_out [*6] |-> !bcast_valid_out) else $error("broadcast while busy");
  chk_lookup_silent: assert property (busy_out && kind_q == 2'h3 |-> !fwd_reply_valid_out)
    else $error("lookup forwarded a reply");
  chk_exit_ok: assert property (cmd_mode_exit_out |-> (result_valid_out && result_out == 2'h1)
    || $past(result_valid_out && result_out == 2'h1)) else $error("mode exit without OK");
  chk_discover_len: assert property ($fell(busy_out) && kind_q == 2'h1 |->
    len_q >= to_cyc && len_q <= to_cyc + 4) else $error("discover length off timeout");
  cover property (cmd_mode_exit_out);
  cover property (result_valid_out && result_out == 2'h2);
  cover property (fwd_reply_valid_out);
endmodule // node_discovery_props
bind node_discovery_control node_discovery_props #(.CYCLES_PER_UNIT(CYCLES_PER_UNIT)) u_node_discovery_props (.*);

// file: tb/radio_nodes_model.sv
// Two remote nodes answering broadcasts: 8'hA1 has a short address, 8'hB2 a long one.
// Assumes one-cycle broadcast pulses on the system clock.
`timescale 1ns/100ps
module radio_nodes_model (
  // Clock
  input wire logic clk_in,
  // Broadcast side
  input wire logic bcast_valid_in,
  input wire logic [1:0] bcast_kind_in,
  input wire logic [31:0] bcast_label_in,
  // Bench control
  input wire logic [7:0] delay_in,
  input wire logic mute_in,
  // Replies
  output logic reply_valid_out = 1'b0,
  output logic [15:0] reply_short_addr_out = 16'h0,
  output logic [31:0] reply_serial_high_out = 32'h0,
  output logic [31:0] reply_serial_low_out = 32'h0
);
  logic [7:0] age_q = 8'h0;
  logic [1:0] who_q = 2'h0;
  wire [1:0] hit = {bcast_label_in == 32'hB2, bcast_label_in == 32'hA1};
  wire [1:0] who_d = mute_in ? 2'h0 : (bcast_kind_in == 2'h1 ? 2'h3 : hit);
  always @(posedge clk_in) begin
    reply_valid_out <= 1'b0;
    // Idle lines keep toggling so stale data never looks valid
    reply_short_addr_out <= ~reply_short_addr_out;
    reply_serial_high_out <= ~reply_serial_high_out;
    reply_serial_low_out <= ~reply_serial_low_out;
    if (bcast_valid_in) begin
      age_q <= 8'h1;
      who_q <= who_d;
    end else if (age_q != 8'h0) begin
      age_q <= age_q + 8'h1;
      if (age_q == delay_in && who_q[0]) begin
        reply_valid_out <= 1'b1;
        reply_short_addr_out <= 16'h1234;
      end
      if (age_q == delay_in + 8'h2 && who_q[1]) begin
        reply_valid_out <= 1'b1;
        reply_short_addr_out <= 16'hFFFE;
        reply_serial_high_out <= 32'h11112222;
        reply_serial_low_out <= 32'h33334444;
      end
    end
  end
endmodule // radio_nodes_model

// file: tb/test_node_discovery_control.sv
// Self-checking bench for node_discovery_control with a rule model per command.
// Assumes the checker bind and the radio node model are compiled alongside.
`timescale 1ns/100ps
module test_node_discovery_control;
  localparam int TO = 2;
  logic clk_sys_in = 1'b0, nrst_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0, mute = 1'b0;
  logic [3:0] avs_address_in = 4'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, bcast_label_out, rd;
  logic [31:0] reply_serial_high_in, reply_serial_low_in;
  logic avs_waitrequest_out, bcast_valid_out, fwd_reply_valid_out, fwd_reply_api_out, result_valid_out;
  logic cmd_mode_exit_out, busy_out, irq_out, reply_valid_in, last_api;
  logic [1:0] bcast_kind_out, result_out, last_res;
  logic [15:0] reply_short_addr_in;
  logic [7:0] result_frame_type_out, last_ft, dly = 8'h2;
  int error_cnt = 0, num_checks = 0, cycles = 0, n_bc, n_fwd, n_res, n_exit;
  always #2 clk_sys_in = ~clk_sys_in;
  node_discovery_control #(.CYCLES_PER_UNIT(10)) u_node_discovery_control (.*);
  radio_nodes_model u_radio_nodes_model (.clk_in(clk_sys_in), .bcast_valid_in(bcast_valid_out),
    .bcast_kind_in(bcast_kind_out), .bcast_label_in(bcast_label_out), .delay_in(dly), .mute_in(mute),
    .reply_valid_out(reply_valid_in), .reply_short_addr_out(reply_short_addr_in),
    .reply_serial_high_out(reply_serial_high_in), .reply_serial_low_out(reply_serial_low_in));
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (bcast_valid_out === 1'b1) n_bc <= n_bc + 1;
    if (fwd_reply_valid_out === 1'b1) begin
      n_fwd <= n_fwd + 1;
      last_api <= fwd_reply_api_out;
    end
    if (cmd_mode_exit_out === 1'b1) n_exit <= n_exit + 1;
    if (result_valid_out === 1'b1) begin
      n_res <= n_res + 1;
      last_res <= result_out;
      last_ft <= result_frame_type_out;
    end
    if (cycles == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    // Sampled right at the rising edge, before the design updates its flops
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    check("waitrequest", avs_waitrequest_out, 0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(negedge clk_sys_in);
  endtask
  task automatic cmd(logic api, logic compat, logic [2:0] c, logic [31:0] lab);
    int m, ex_res, ex_end, t0;
    bus(1, 4'h0, {31'h0, api});
    bus(1, 4'h3, {30'h0, compat, 1'b0});
    bus(1, 4'hA, lab);
    bus(1, 4'h4, 32'hFFFFFFFF);
    bus(1, 4'h5, 32'hFFFFFFFF);
    dly <= 8'($urandom % 5 + 2);
    m = mute ? 0 : (c[1:0] == 2'h1 ? 2 : int'(lab == 32'hA1) + int'(lab == 32'hB2));
    ex_end = 1;
    case (c[1:0])
      2'h1: ex_res = api ? ((compat && m == 0) ? 1 : 0) : 3;
      2'h2: begin
        ex_res = compat ? 1 : (m == 0 ? 2 : (api ? -1 : 3));
        ex_end = compat || m == 0;
      end
      default: begin
        ex_res = (c[2] && m > 0) ? 1 : 2;
        ex_end = c[2] && m == 0;
      end
    endcase
    {n_bc, n_fwd, n_res, n_exit} = '0;
    t0 = cycles;
    bus(1, 4'h1, {29'h0, c});
    repeat (2) @(posedge clk_sys_in);
    if (ex_end != 0) bus(1, 4'h1, 32'h3);
    while (busy_out !== 1'b0 && cycles < t0 + 200) @(negedge clk_sys_in);
    check("ends_in_time", busy_out, 0);
    check("ends_at_timeout", cycles - t0 >= TO * 10, ex_end);
    repeat (3) @(negedge clk_sys_in);
    check("bcast", n_bc, c != 3'h3);
    check("fwd", n_fwd, c[1:0] == 2'h3 ? 0 : m);
    if (m > 0 && c[1:0] != 2'h3) check("fwd_api", last_api, api);
    check("results", n_res, ex_res > 0);
    if (ex_res > 0) check("result", last_res, ex_res);
    if (ex_res > 0) check("frame", last_ft, api ? 8'h88 : 8'h0);
    check("exit", n_exit, c == 3'h7 && ex_res == 1 && !api);
    if (c[1:0] == 2'h3) begin
      bus(0, 4'h4, 0);
      check("dest_hi", rd, ex_res == 2 ? 32'hFFFFFFFF : (lab == 32'hA1 ? 0 : 32'h11112222));
      bus(0, 4'h5, 0);
      check("dest_lo", rd, ex_res == 2 ? 32'hFFFFFFFF : (lab == 32'hA1 ? 32'h1234 : 32'h33334444));
    end
  endtask
  initial begin
    void'($urandom(32'h7E98));
    repeat (4) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    bus(0, 4'h2, 0);
    check("timeout_reset", rd, 32'h19);
    bus(0, 4'hB, 0);
    check("unmapped", rd, 0);
    bus(1, 4'h2, TO);
    bus(1, 4'h8, 0);
    cmd(0, 0, 3'h1, 32'h0);
    check("irq_masked", irq_out, 0);
    bus(0, 4'h7, 0);
    check("done_flag", rd[0], 1);
    check("irq_flags", rd[3:1], 3'h6);
    bus(1, 4'h8, 32'h1);
    check("irq_on", irq_out, 1);
    bus(1, 4'h9, 32'hF);
    check("irq_clear", irq_out, 0);
    mute <= 1'b1;
    cmd(1, 0, 3'h1, 32'h0);
    cmd(1, 1, 3'h1, 32'h0);
    mute <= 1'b0;
    cmd(1, 1, 3'h1, 32'h0);
    cmd(0, 0, 3'h6, 32'hA1);
    cmd(0, 0, 3'h6, 32'hC3);
    cmd(1, 0, 3'h6, 32'hA1);
    cmd(1, 0, 3'h6, 32'hC3);
    cmd(1, 1, 3'h6, 32'hA1);
    cmd(0, 1, 3'h6, 32'hC3);
    cmd(0, 0, 3'h7, 32'hA1);
    cmd(1, 0, 3'h7, 32'hB2);
    cmd(0, 0, 3'h3, 32'hA1);
    cmd(1, 0, 3'h7, 32'hC3);
    wrap_up();
  end
endmodule // test_node_discovery_control
